//--- inc/irf_bus_if.sv
`timescale 1ns/1ps
interface irf_bus_if;
    logic       we;
    logic [7:0] adr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic       hit;
    modport slave  (input we, adr, wdat, output rdat, hit);
    modport master (output we, adr, wdat, input rdat, hit);
endinterface : irf_bus_if

//--- inc/irf_pkg.sv
package irf_pkg;
    // ************************************************************
    // Register offsets (word indices, each register one word)
    // ************************************************************
    localparam logic [7:0] IRQ_CONTROL_IDX   = 8'h0b;
    localparam logic [7:0] PERIPH_FLAGS_IDX  = 8'h0c;
    localparam logic [7:0] PERIPH_ENAB_IDX   = 8'h8c;
    localparam logic [7:0] POWER_CTRL_IDX    = 8'h8e;
    localparam logic [7:0] WAKE_STATUS_IDX   = 8'hf0;
    localparam logic [7:0] WAKE_MASK_IDX     = 8'hf1;
    localparam logic [7:0] CORE_STATE_IDX    = 8'hf2;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int GLB_EN_BIT  = 7;
    localparam int PER_EN_BIT  = 6;
    localparam int TMR_EN_BIT  = 5;
    localparam int EXT_EN_BIT  = 4;
    localparam int PCH_EN_BIT  = 3;
    localparam int TMR_FLG_BIT = 2;
    localparam int EXT_FLG_BIT = 1;
    localparam int PCH_FLG_BIT = 0;
    localparam int CMP_BIT  = 6;
    localparam int BOR_BIT  = 0;
    localparam int POR_BIT  = 1;

    // ************************************************************
    // Reset and vector values
    // ************************************************************
    localparam logic [7:0]  IRQ_CONTROL_RST = 8'h00;
    localparam logic [7:0]  PERIPH_RST      = 8'h00;
    localparam logic [1:0]  POWER_CTRL_RST  = 2'h0;
    localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
    localparam logic [12:0] RESET_VECTOR    = 13'h0000;

    typedef enum logic [2:0] {
        RST_NONE  = 3'b000,
        RST_POR   = 3'b001,
        RST_PIN   = 3'b010,
        RST_WDT   = 3'b011,
        RST_BOR   = 3'b100
    } irf_reset_type;
endpackage : irf_pkg

//--- rtl/irf_core.sv
`timescale 1ns/1ps
// Contract
// - An interrupt wake-up from sleep with global enable set loads the vector 0004h.
// - A wake-up from sleep sets the flag bits that identify its cause.
// - A comparator wake-up sets peripheral flag bit 6; other wake-ups leave it alone.
// - A brown-out reset clears power control bit 0; other resets leave it unchanged.
// - A supply collapse during a reset is handled as a power-on reset.
// - irq_control holds global, peripheral, timer, pin, port enables then three flags.
// - Master-clear, brown-out and watchdog resets apply the non-power-on values.
// - Unimplemented bits read as zero.
// - Interrupt entry pushes only the return address; W and status are not saved.
module irf_core (
    input  wire logic        SYS_CLK_I,          // 100 MHz clock
    input  wire logic        RESET_N_I,          // Sync reset, active low
    input  wire logic        WB_CYC_I,           // Wishbone cycle
    input  wire logic        WB_STB_I,           // Wishbone strobe
    input  wire logic        WB_WE_I,            // Wishbone write
    input  wire logic [7:0]  WB_ADR_I,           // Wishbone word index
    input  wire logic [31:0] WB_DAT_I,           // Wishbone write data
    input  wire logic [3:0]  WB_SEL_I,           // Wishbone byte selects
    output logic      [31:0] WB_DAT_O,           // Wishbone read data
    output logic             WB_ACK_O,           // Wishbone acknowledge
    input  wire logic [2:0]  RESET_KIND_I,       // Reset event, irf_reset_type
    input  wire logic        SUPPLY_COLLAPSE_I,  // Supply fell too low in reset
    input  wire logic        TIMER_OVF_I,        // Timer overflow event
    input  wire logic        EXT_PIN_I,          // External pin edge event
    input  wire logic        PORTB_CHANGE_I,     // Port change event
    input  wire logic        CMP_CHANGE_I,       // Comparator output change
    input  wire logic        SLEEP_I,            // Core is asleep
    input  wire logic        IRQ_ACK_I,          // Core takes the interrupt
    input  wire logic [12:0] PC_I,               // Next PC, pushed on entry
    output logic             IRQ_O,              // Interrupt request to core
    output logic             WAKE_O,             // Wake-up pulse to core
    output logic             PC_LOAD_O,          // Load PC pulse
    output logic      [12:0] PC_VALUE_O,         // PC value to load
    output logic             PUSH_O,             // Stack push pulse
    output logic      [12:0] PUSH_DATA_O,        // Return address pushed
    output logic             INT_O               // Wake-status interrupt
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    irf_bus_if bus ();
    logic wr;
    logic [7:0] wd;

    irf_wb_slave u_slave (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .cyc_i   (WB_CYC_I),
        .stb_i   (WB_STB_I),
        .we_i    (WB_WE_I),
        .adr_i   (WB_ADR_I),
        .dat_i   (WB_DAT_I),
        .sel_i   (WB_SEL_I[0]),
        .dat_o   (WB_DAT_O),
        .ack_o   (WB_ACK_O),
        .wr_o    (wr),
        .reg_bus (bus.master)
    );
    assign wd = bus.wdat;

    function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                    input logic [7:0] idx);
        return w && (a == idx);
    endfunction : wr_hit

    // ************************************************************
    // Reset classification
    // ************************************************************
    irf_pkg::irf_reset_type kind;
    logic reset_ev;
    logic por_ev;
    logic other_ev;
    assign kind     = irf_pkg::irf_reset_type'(RESET_KIND_I);
    assign reset_ev = (kind != irf_pkg::RST_NONE);
    assign por_ev   = (kind == irf_pkg::RST_POR) || (reset_ev && SUPPLY_COLLAPSE_I);
    assign other_ev = reset_ev && !por_ev;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] ctl_q;
    logic       cmp_flag_q;
    logic       cmp_en_q;
    logic [1:0] pwr_ctl_q;
    logic       asleep_q;
    logic [1:0] wst_q;
    logic [1:0] wmask_q;
    logic       wake;
    logic       cmp_wake;
    logic       any_wake;
    logic       port_chg_d;

    // Wake needs an enabled source event in the same cycle; global enable only decides vectoring
    assign cmp_wake = SLEEP_I && CMP_CHANGE_I && cmp_en_q && ctl_q[irf_pkg::PER_EN_BIT];
    assign any_wake = (TIMER_OVF_I && ctl_q[irf_pkg::TMR_EN_BIT])
                   || (EXT_PIN_I && ctl_q[irf_pkg::EXT_EN_BIT])
                   || (PORTB_CHANGE_I && ctl_q[irf_pkg::PCH_EN_BIT]);
    assign wake = SLEEP_I && !reset_ev && (any_wake || cmp_wake);

    // Power-on leaves the port-change flag unknown; zero is a legal pick
    always_comb begin
        port_chg_d = ctl_q[irf_pkg::PCH_FLG_BIT];
        if (por_ev) begin
            port_chg_d = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            ctl_q <= irf_pkg::IRQ_CONTROL_RST;
        end else if (reset_ev) begin
            ctl_q <= {7'h00, port_chg_d};
        end else begin
            if (wr_hit(wr, bus.adr, irf_pkg::IRQ_CONTROL_IDX)) begin
                ctl_q <= wd;
            end
            // Hardware set wins over a software clear in the same cycle
            if (TIMER_OVF_I) ctl_q[irf_pkg::TMR_FLG_BIT] <= 1'b1;
            if (EXT_PIN_I) ctl_q[irf_pkg::EXT_FLG_BIT] <= 1'b1;
            if (PORTB_CHANGE_I) ctl_q[irf_pkg::PCH_FLG_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            cmp_flag_q <= 1'b0;
            cmp_en_q   <= 1'b0;
        end else if (reset_ev) begin
            cmp_flag_q <= 1'b0;
            cmp_en_q   <= 1'b0;
        end else begin
            if (wr_hit(wr, bus.adr, irf_pkg::PERIPH_FLAGS_IDX)) begin
                cmp_flag_q <= wd[irf_pkg::CMP_BIT];
            end
            if (wr_hit(wr, bus.adr, irf_pkg::PERIPH_ENAB_IDX)) begin
                cmp_en_q <= wd[irf_pkg::CMP_BIT];
            end
            // Only a comparator change or a bus write sets bit 6; other wakes leave it
            if (CMP_CHANGE_I) cmp_flag_q <= 1'b1;
        end
    end

    // Power control: bit 1 marks power-on (cleared), bit 0 marks brown-out
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            pwr_ctl_q <= irf_pkg::POWER_CTRL_RST;
        end else if (por_ev) begin
            pwr_ctl_q[irf_pkg::POR_BIT] <= 1'b0;
        end else if (kind == irf_pkg::RST_BOR) begin
            pwr_ctl_q[irf_pkg::BOR_BIT] <= 1'b0;
        end else if (!reset_ev && wr_hit(wr, bus.adr, irf_pkg::POWER_CTRL_IDX)) begin
            pwr_ctl_q <= wd[1:0];
        end
    end

    // ************************************************************
    // Request, wake and entry
    // ************************************************************
    logic tmr_req;
    logic ext_req;
    logic rb_req;
    logic per_req;
    assign tmr_req = ctl_q[irf_pkg::TMR_EN_BIT] && ctl_q[irf_pkg::TMR_FLG_BIT];
    assign ext_req = ctl_q[irf_pkg::EXT_EN_BIT] && ctl_q[irf_pkg::EXT_FLG_BIT];
    assign rb_req  = ctl_q[irf_pkg::PCH_EN_BIT] && ctl_q[irf_pkg::PCH_FLG_BIT];
    assign per_req = ctl_q[irf_pkg::PER_EN_BIT] && cmp_en_q && cmp_flag_q;

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= ctl_q[irf_pkg::GLB_EN_BIT] && !reset_ev
                  && (tmr_req || ext_req || rb_req || per_req);
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            WAKE_O     <= 1'b0;
            PC_LOAD_O  <= 1'b0;
            PC_VALUE_O <= irf_pkg::RESET_VECTOR;
            asleep_q   <= 1'b0;
        end else begin
            asleep_q  <= SLEEP_I;
            WAKE_O    <= wake;
            PC_LOAD_O <= 1'b0;
            if (reset_ev) begin
                PC_LOAD_O  <= 1'b1;
                PC_VALUE_O <= irf_pkg::RESET_VECTOR;
            end else if (wake && ctl_q[irf_pkg::GLB_EN_BIT]) begin
                PC_LOAD_O  <= 1'b1;
                PC_VALUE_O <= irf_pkg::IRQ_VECTOR;
            end else if (IRQ_ACK_I && IRQ_O) begin
                PC_LOAD_O  <= 1'b1;
                PC_VALUE_O <= irf_pkg::IRQ_VECTOR;
            end
        end
    end

    // Only the return address is pushed; W and status are left to software
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            PUSH_O      <= 1'b0;
            PUSH_DATA_O <= 13'h0000;
        end else begin
            PUSH_O <= !reset_ev && ((wake && ctl_q[irf_pkg::GLB_EN_BIT])
                                    || (IRQ_ACK_I && IRQ_O));
            PUSH_DATA_O <= PC_I;
        end
    end

    // Entry leaves global enable set; software must clear it to avoid re-entry
    // ************************************************************
    // Wake status, sticky with write-one-to-clear
    // ************************************************************
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            wst_q   <= 2'h0;
            wmask_q <= 2'h0;
        end else begin
            if (wr_hit(wr, bus.adr, irf_pkg::WAKE_STATUS_IDX)) begin
                wst_q <= wst_q & ~wd[1:0];
            end
            if (wr_hit(wr, bus.adr, irf_pkg::WAKE_MASK_IDX)) begin
                wmask_q <= wd[1:0];
            end
            if (wake) wst_q[0] <= 1'b1;
            if (reset_ev) wst_q[1] <= 1'b1;
        end
    end
    assign INT_O = |(wst_q & wmask_q);

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        bus.hit  = 1'b1;
        bus.rdat = 8'h00;
        if (bus.adr == irf_pkg::IRQ_CONTROL_IDX) begin
            bus.rdat = ctl_q;
        end else if (bus.adr == irf_pkg::PERIPH_FLAGS_IDX) begin
            bus.rdat = {1'b0, cmp_flag_q, 6'h00};
        end else if (bus.adr == irf_pkg::PERIPH_ENAB_IDX) begin
            bus.rdat = {1'b0, cmp_en_q, 6'h00};
        end else if (bus.adr == irf_pkg::POWER_CTRL_IDX) begin
            bus.rdat = {6'h00, pwr_ctl_q};
        end else if (bus.adr == irf_pkg::WAKE_STATUS_IDX) begin
            bus.rdat = {6'h00, wst_q};
        end else if (bus.adr == irf_pkg::WAKE_MASK_IDX) begin
            bus.rdat = {6'h00, wmask_q};
        end else if (bus.adr == irf_pkg::CORE_STATE_IDX) begin
            bus.rdat = {6'h00, IRQ_O, asleep_q};
        end else begin
            bus.hit = 1'b0;
        end
    end
endmodule : irf_core

//--- rtl/irf_wb_slave.sv
`timescale 1ns/1ps
module irf_wb_slave (
    input  wire logic        clk_i,     // System clock
    input  wire logic        rst_n_i,   // Synchronous reset
    input  wire logic        cyc_i,     // Wishbone cycle
    input  wire logic        stb_i,     // Wishbone strobe
    input  wire logic        we_i,      // Write enable
    input  wire logic [7:0]  adr_i,     // Word index
    input  wire logic [31:0] dat_i,     // Write data
    input  wire logic        sel_i,     // Byte lane 0 select
    output logic      [31:0] dat_o,     // Read data
    output logic             ack_o,     // Acknowledge
    output logic             wr_o,      // One-cycle write strobe
    irf_bus_if.master        reg_bus    // Register side
);
    logic [31:0] dat_q;
    logic        ack_q;

    assign reg_bus.we   = we_i;
    assign reg_bus.adr  = adr_i;
    assign reg_bus.wdat = dat_i[7:0];
    // Write lands at the edge where the master samples ack high
    assign wr_o  = cyc_i && stb_i && we_i && sel_i && ack_q;
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dat_q <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_q) begin
            dat_q <= reg_bus.hit ? {24'h00_0000, reg_bus.rdat} : 32'h0000_0000;
        end
    end
endmodule : irf_wb_slave

//--- sim/irf_core_asserts.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module irf_chk (
    input  wire logic        SYS_CLK_I,    // Clock
    input  wire logic        RESET_N_I,    // Reset
    input  wire logic        WB_CYC_I,     // Cycle
    input  wire logic        WB_STB_I,     // Strobe
    input  wire logic [31:0] WB_DAT_O,     // Read data
    input  wire logic        WB_ACK_O,     // Ack
    input  wire logic [2:0]  RESET_KIND_I, // Reset event
    input  wire logic        SLEEP_I,      // Asleep
    input  wire logic        IRQ_ACK_I,    // Entry
    input  wire logic [12:0] PC_I,         // Next PC
    input  wire logic        IRQ_O,        // Request
    input  wire logic        WAKE_O,       // Wake
    input  wire logic        PC_LOAD_O,    // PC load
    input  wire logic [12:0] PC_VALUE_O,   // PC value
    input  wire logic        PUSH_O,       // Push
    input  wire logic [12:0] PUSH_DATA_O   // Pushed PC
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked");
    ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    rdat_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read bits not zero");
    rst_vector_a: assert property (RESET_KIND_I != 3'h0 |=> PC_LOAD_O
        && PC_VALUE_O == irf_pkg::RESET_VECTOR) else $error("reset did not load PC");
    push_vector_a: assert property (PUSH_O |-> PC_LOAD_O && PC_VALUE_O == 13'h0004)
        else $error("push without vector load");
    push_data_a: assert property (PUSH_O |-> PUSH_DATA_O == $past(PC_I))
        else $error("wrong return address pushed");
    entry_push_a: assert property (IRQ_ACK_I && IRQ_O && RESET_KIND_I == 3'h0 |=> PUSH_O)
        else $error("entry did not push");
    wake_sleep_a: assert property ($rose(WAKE_O) |-> $past(SLEEP_I))
        else $error("wake while not asleep");

    cover property (WAKE_O && PUSH_O);
    cover property (WAKE_O && !PC_LOAD_O);
    cover property (RESET_KIND_I == 3'h4);
    cover property (IRQ_ACK_I && IRQ_O);
endmodule : irf_chk

bind irf_core irf_chk u_chk (.SYS_CLK_I, .RESET_N_I, .WB_CYC_I, .WB_STB_I, .WB_DAT_O,
    .WB_ACK_O, .RESET_KIND_I, .SLEEP_I, .IRQ_ACK_I, .PC_I, .IRQ_O, .WAKE_O, .PC_LOAD_O,
    .PC_VALUE_O, .PUSH_O, .PUSH_DATA_O);

//--- sim/test_irf_core.sv
`timescale 1ns/1ps
module test_irf_core;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        coll = 1'b0, slp = 1'b0, iack = 1'b0, ack, irq, wake, pcl, push, intr;
    logic [3:0]  ev = 4'h0;
    logic [2:0]  kind = 3'h0;
    logic [7:0]  adr = 8'h0;
    logic [12:0] pc = 13'h0abc, pcv, pushd;
    logic [31:0] wdat = 32'h0, rdat;
    int          n_mismatch = 0, total_checks = 0, cycles = 0;

    irf_core u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'h1), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .RESET_KIND_I(kind), .SUPPLY_COLLAPSE_I(coll), .TIMER_OVF_I(ev[0]),
        .EXT_PIN_I(ev[1]), .PORTB_CHANGE_I(ev[2]), .CMP_CHANGE_I(ev[3]), .SLEEP_I(slp),
        .IRQ_ACK_I(iack), .PC_I(pc), .IRQ_O(irq), .WAKE_O(wake), .PC_LOAD_O(pcl),
        .PC_VALUE_O(pcv), .PUSH_O(push), .PUSH_DATA_O(pushd), .INT_O(intr));

    always #5 clk = ~clk;

    // ****************
    // Shared tasks
    // ****************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Called just after an edge; ack and data are registered, so sampling here is safe
    task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        chk(ack === 1'b1, "no ack");
        r = rdat[7:0];
        chk(rdat[31:8] === 24'h0, "upper data");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, e);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(r === e, "read value");
    endtask : rd

    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(posedge clk);
    endtask : pulse

    task automatic hold(input bit w);
        int n;
        n = 0;
        while ((w ? wake : push) !== 1'b1 && n < 6) begin
            n++;
            @(posedge clk);
        end
        chk((w ? wake : push) === 1'b1, "no pulse");
    endtask : hold

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        rd(8'h0b, 8'h00);
        rd(8'h0c, 8'h00);
        rd(8'h8c, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'hff);
        wr(8'h0c, 8'hff);
        rd(8'h0c, 8'h40);
        wr(8'h8c, 8'hff);
        rd(8'h8c, 8'h40);
        wr(8'h0c, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h0b, 8'h00);
        wr(8'hf2, 8'hff);
        rd(8'hf2, 8'h00);
    endtask : t_regs

    task automatic t_irq();
        for (int i = 0; i < 3; i++) begin
            wr(8'h0b, 8'h20 >> i);
            pulse(i);
            tick(2);
            chk(irq === 1'b0, "request without global enable");
            rd(8'h0b, 8'h24 >> i);
            wr(8'h0b, 8'h80 | (8'h24 >> i));
            tick(2);
            chk(irq === 1'b1, "no request");
            wr(8'h0b, 8'h80 | (8'h20 >> i));
            tick(2);
            chk(irq === 1'b0, "request after clear");
        end
        wr(8'h8c, 8'h40);
        wr(8'h0b, 8'h80);
        pulse(3);
        tick(2);
        chk(irq === 1'b0, "peripheral without its enable");
        wr(8'h0b, 8'hc0);
        tick(2);
        chk(irq === 1'b1, "no peripheral request");
        wr(8'h0c, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h0b, 8'ha0);
        pulse(0);
        tick(2);
        iack <= 1'b1;
        @(posedge clk);
        iack <= 1'b0;
        hold(1'b0);
        chk(pushd === pc && pcv === 13'h0004, "entry push");
        wr(8'h0b, 8'h00);
    endtask : t_irq

    task automatic t_wake();
        wr(8'hf1, 8'h01);
        wr(8'h0b, 8'h90);
        slp <= 1'b1;
        pulse(1);
        hold(1'b1);
        chk(pcl === 1'b1 && pcv === 13'h0004 && push === 1'b1, "vector");
        slp <= 1'b0;
        rd(8'h0b, 8'h92);
        rd(8'h0c, 8'h00);
        chk(intr === 1'b1, "wake interrupt");
        wr(8'hf1, 8'h00);
        chk(intr === 1'b0, "masked interrupt");
        wr(8'hf0, 8'h01);
        wr(8'hf1, 8'h01);
        chk(intr === 1'b0, "cleared interrupt");
        wr(8'h0b, 8'h40);
        wr(8'h8c, 8'h40);
        slp <= 1'b1;
        pulse(3);
        hold(1'b1);
        chk(pcl === 1'b0, "vector without global enable");
        slp <= 1'b0;
        rd(8'h0c, 8'h40);
        wr(8'h0c, 8'h00);
        wr(8'h8c, 8'h00);
    endtask : t_wake

    // Kinds 1..4 in turn, then master clear with the supply collapsed
    task automatic t_resets();
        logic [7:0] r;
        logic       por;
        for (int k = 1; k < 6; k++) begin
            wr(8'h8e, 8'h03);
            wr(8'h0b, 8'hf9);
            wr(8'h0c, 8'h40);
            wr(8'h8c, 8'h40);
            kind <= (k == 5) ? 3'h2 : 3'(k);
            coll <= (k == 5);
            @(posedge clk);
            kind <= 3'h0;
            coll <= 1'b0;
            tick(2);
            por = (k == 1 || k == 5);
            rd(8'h0b, por ? 8'h00 : 8'h01);
            rd(8'h0c, 8'h00);
            rd(8'h8c, 8'h00);
            wb(1'b0, 8'h8e, 8'h00, r);
            chk(r[1] === !por, "power-on bit");
            if (!por) begin
                chk(r[0] === (k != 4), "brown-out bit");
            end
        end
    endtask : t_resets

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        t_regs();
        t_irq();
        t_wake();
        t_resets();
        stop_test();
    end
endmodule : test_irf_core
